/* rtl/swt_timers.sv */
// two wakeup down-counters with slow clock calibration, avalon slave
//
// Operation
// - two 32-bit counters, one decrement per tick
// - deep sleep halts both counters
// - per-timer choice to run during sleep
// - zero crossing raises enabled interrupt or wakeup
// - counter keeps decrementing past zero until stopped
// - writing a count loads and starts timer
// - stop freezes value, no interrupt afterwards
// - running bit readable per timer
// - expired flag set when masked, read clears
// - calibration enable zeroes ref, starts timer 0
// - reference counts fast clock, holds at zero
// - twenty ticks nominal give ten thousand counts
// - slow clock from internal rc or external pin
module swt_timers
   import swt_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        rc_osc_clk,
   input  wire logic        external_slow_ref_input,
   input  wire logic        sleep_active,
   input  wire logic        deep_sleep_active,
   output logic             irq,
   output logic             wake_event
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_DONE} swt_cal_t;

   typedef struct packed {
      logic [1:0][31:0] cnt;
      logic [1:0]       run;
      logic [1:0]       expd;
      logic [1:0]       imask;
      logic [3:0]       ctrl;
      logic [31:0]      calref;
      logic [15:0]      xph;
      swt_cal_t         cal;
      logic             ack;
      logic [31:0]      rdata;
   } swt_state_t;

   swt_state_t s_q;
   swt_state_t s_d;
   swt_req_t   req;
   swt_rsp_t   rsp;

   logic [1:0] sl_rise;
   logic       slow_src;
   logic       tick;

   assign req.read      = avs_read;
   assign req.write     = avs_write;
   assign req.address   = avs_address;
   assign req.writedata = avs_writedata;

   // ****************************************************************
   // slow clock select and crossing
   // ****************************************************************
   // sampled as a level: the slow clock is far below mclk/2
   swt_sync #(.W(2)) u_sync
   (
      .mclk     (mclk),
      .arst_n   (arst_n),
      .async_in ({external_slow_ref_input, rc_osc_clk}),
      .level    (),
      .rise     (sl_rise)
   );

   // selecting after sync avoids a glitch on the source mux
   assign slow_src = s_q.ctrl[SWT_CTRL_EXTSRC];
   assign tick     = slow_src ? sl_rise[1] : sl_rise[0];

   // ****************************************************************
   // next state
   // ****************************************************************
   logic [3:0]  idx;
   logic        wr;
   logic        rd;
   logic [1:0]  zero_hit;
   logic [1:0]  adv;
   logic [1:0]  stop_cmd;
   logic [1:0]  load_cmd;
   logic        cal_start;
   logic [15:0] xph_sum;
   logic        xtal_en;

   always_comb
   begin
      s_d       = s_q;
      idx       = req.address[5:2];
      wr        = req.write & ~s_q.ack;
      rd        = req.read & ~s_q.ack;
      zero_hit  = 2'h0;
      adv       = 2'h0;
      stop_cmd  = 2'h0;
      load_cmd  = 2'h0;
      cal_start = 1'b0;

      // 16 of every 20 mclk edges carry a crystal tick, no second clock
      xph_sum = s_q.xph + 16'(SWT_XTAL_STEP);
      xtal_en = (xph_sum >= 16'(SWT_XTAL_MOD));
      s_d.xph = xtal_en ? xph_sum - 16'(SWT_XTAL_MOD) : xph_sum;

      // one wait state per access, answer on the second edge
      s_d.ack = (req.read | req.write) & ~s_q.ack;

      if (wr && idx == SWT_IDX_CMD)
      begin
         stop_cmd = req.writedata[1:0];
      end
      load_cmd[0] = wr && idx == SWT_IDX_LOAD0;
      load_cmd[1] = wr && idx == SWT_IDX_LOAD1;
      cal_start   = wr && idx == SWT_IDX_CTRL
                    && req.writedata[SWT_CTRL_CALEN]
                    && !s_q.ctrl[SWT_CTRL_CALEN];

      for (int i = 0; i < 2; i++)
      begin
         adv[i] = tick && s_q.run[i] && !deep_sleep_active
                  && !(sleep_active && !s_q.ctrl[i]);
         if (adv[i])
         begin
            s_d.cnt[i] = s_q.cnt[i] - 32'h1;
            zero_hit[i] = (s_q.cnt[i] == 32'h1);
         end
         if (stop_cmd[i])
         begin
            s_d.run[i] = 1'b0;
            zero_hit[i] = 1'b0;
         end
         if (load_cmd[i])
         begin
            s_d.cnt[i] = req.writedata;
            s_d.run[i] = 1'b1;
            zero_hit[i] = 1'b0;
         end
      end

      if (wr && idx == SWT_IDX_CTRL)
      begin
         s_d.ctrl = req.writedata[3:0];
      end
      if (wr && idx == SWT_IDX_IMASK)
      begin
         s_d.imask = req.writedata[1:0];
      end

      // calibration: timer 0 counts down while ref counts crystal rate enables
      unique case (s_q.cal)
         CAL_IDLE:
         begin
            if (cal_start)
            begin
               s_d.calref = 32'h0;
               s_d.run[0] = 1'b1;
               s_d.cal    = CAL_RUN;
            end
         end
         CAL_RUN:
         begin
            // counts only on the crystal rate enable
            if (xtal_en)
            begin
               s_d.calref = s_q.calref + 32'h1;
            end
            if (zero_hit[0] || !s_q.ctrl[SWT_CTRL_CALEN])
            begin
               s_d.cal = CAL_DONE;
            end
         end
         CAL_DONE:
         begin
            if (!s_q.ctrl[SWT_CTRL_CALEN])
            begin
               s_d.cal = CAL_IDLE;
            end
         end
         default:
         begin
            s_d.cal = CAL_IDLE;
         end
      endcase

      // read clears flags; a new hit in the same cycle wins
      if (rd && idx == SWT_IDX_EXP)
      begin
         s_d.expd = 2'h0;
      end
      if (wr && idx == SWT_IDX_EXP)
      begin
         s_d.expd = s_q.expd & ~req.writedata[1:0];
      end
      s_d.expd = s_d.expd | zero_hit;

      if (rd)
      begin
         unique case (idx)
            SWT_IDX_CTRL:   s_d.rdata = {28'h0, s_q.ctrl};
            SWT_IDX_LOAD0:  s_d.rdata = s_q.cnt[0];
            SWT_IDX_LOAD1:  s_d.rdata = s_q.cnt[1];
            SWT_IDX_CNT0:   s_d.rdata = s_q.cnt[0];
            SWT_IDX_CNT1:   s_d.rdata = s_q.cnt[1];
            SWT_IDX_STAT:   s_d.rdata = {29'h0, s_q.cal == CAL_DONE,
                                         s_q.run};
            SWT_IDX_EXP:    s_d.rdata = {30'h0, s_q.expd};
            SWT_IDX_IMASK:  s_d.rdata = {30'h0, s_q.imask};
            SWT_IDX_CALREF: s_d.rdata = s_q.calref;
            default:        s_d.rdata = 32'h0;
         endcase
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_q.cnt    <= '0;
         s_q.run    <= 2'h0;
         s_q.expd   <= 2'h0;
         s_q.imask  <= SWT_IMASK_RST;
         s_q.ctrl   <= SWT_CTRL_RST[3:0];
         s_q.calref <= 32'h0;
         s_q.xph    <= 16'h0;
         s_q.cal    <= CAL_IDLE;
         s_q.ack    <= 1'b0;
         s_q.rdata  <= 32'h0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign rsp.waitrequest = (req.read | req.write) & ~s_q.ack;
   assign rsp.readdata    = s_q.rdata;
   assign avs_waitrequest = rsp.waitrequest;
   assign avs_readdata    = rsp.readdata;
   assign irq        = |(s_q.expd & s_q.imask);
   assign wake_event = irq & sleep_active;

endmodule // swt_timers

/* rtl/swt_pkg.sv */
// package for the sleep wakeup timer block: map, fields, timing, carriers
package swt_pkg;

   // ****************************************************************
   // register map (byte addresses, word index = address / 4)
   // ****************************************************************
   localparam logic [3:0] SWT_IDX_CTRL   = 4'h0;
   localparam logic [3:0] SWT_IDX_LOAD0  = 4'h1;
   localparam logic [3:0] SWT_IDX_LOAD1  = 4'h2;
   localparam logic [3:0] SWT_IDX_CNT0   = 4'h3;
   localparam logic [3:0] SWT_IDX_CNT1   = 4'h4;
   localparam logic [3:0] SWT_IDX_STAT   = 4'h5;
   localparam logic [3:0] SWT_IDX_EXP    = 4'h6;
   localparam logic [3:0] SWT_IDX_IMASK  = 4'h7;
   localparam logic [3:0] SWT_IDX_CALREF = 4'h8;
   localparam logic [3:0] SWT_IDX_CMD    = 4'h9;

   // ctrl fields
   localparam int SWT_CTRL_SLEEPRUN0 = 0;
   localparam int SWT_CTRL_SLEEPRUN1 = 1;
   localparam int SWT_CTRL_EXTSRC    = 2;
   localparam int SWT_CTRL_CALEN     = 3;
   localparam logic [31:0] SWT_CTRL_RST = 32'h0000_0003;

   // cmd fields (write-only pulses)
   localparam int SWT_CMD_STOP0 = 0;
   localparam int SWT_CMD_STOP1 = 1;

   // status fields: running0/1 at bits 0/1, calibration done at bit 2
   localparam int SWT_STAT_CALDONE = 2;

   // interrupt status/mask: expired0, expired1 at bits 0,1
   localparam logic [1:0] SWT_IMASK_RST = 2'h0;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int SWT_MCLK_HZ   = 20_000_000;
   localparam int SWT_TICK_HZ   = 32_000;
   localparam int SWT_TICK_DIV  = SWT_MCLK_HZ / SWT_TICK_HZ;
   localparam int SWT_CAL_TICKS = 20;
   localparam int SWT_CAL_NOM   = 10000;
   // crystal rate as a phase step per mclk, in kHz to keep it narrow
   localparam int SWT_XTAL_HZ   = 16_000_000;
   localparam int SWT_XTAL_STEP = SWT_XTAL_HZ / 1000;
   localparam int SWT_XTAL_MOD  = SWT_MCLK_HZ / 1000;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic        read;
      logic        write;
      logic [5:0]  address;
      logic [31:0] writedata;
   } swt_req_t;

   typedef struct packed {
      logic        waitrequest;
      logic [31:0] readdata;
   } swt_rsp_t;

endpackage

/* rtl/swt_sync.sv */
// two flop synchroniser with edge output, one bit per generate entry
module swt_sync
   import swt_pkg::*;
#(
   parameter int W = 2
)
(
   input  wire logic         mclk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise
);
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++)
      begin : g_bit
         logic [2:0] sh_q;
         always_ff @(posedge mclk or negedge arst_n)
         begin
            if (!arst_n)
               sh_q <= 3'h0;
            else
               sh_q <= {sh_q[1:0], async_in[gi]};
         end
         // first flop feeds only the second one
         assign level[gi] = sh_q[1];
         assign rise[gi]  = sh_q[1] & ~sh_q[2];
      end
   endgenerate
endmodule // swt_sync

/* sim/swt_timers_sva.sv */
// port level assertions for the wakeup timer block
module swt_timers_sva
(
   input wire logic        mclk,
   input wire logic        arst_n,
   input wire logic [5:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        sleep_active,
   input wire logic        deep_sleep_active,
   input wire logic        irq,
   input wire logic        wake_event
);
   // ****************************************
   // bus and event checks
   // ****************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   sequence done_s;
      (avs_read || avs_write) && !avs_waitrequest;
   endsequence
   sequence exp_rd_s;
      done_s ##0 avs_read && avs_address[5:2] == 4'h6;
   endsequence
   wake_link_a: assert property (wake_event == (irq && sleep_active))
      else $error("wake event differs from irq and sleep");
   wait_first_a: assert property ((avs_read || avs_write)
      && !$past(avs_read || avs_write) |-> avs_waitrequest)
      else $error("no wait state in first cycle");
   wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
      else $error("more than one wait state");
   rdata_hold_a: assert property (!(avs_read && avs_waitrequest)
      |=> $stable(avs_readdata))
      else $error("read data moved without a read");
   unmapped_a: assert property (done_s ##0 avs_read && avs_address[5:2] > 4'h9
      |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   exp_clear_a: assert property (exp_rd_s |=> ##1 !irq)
      else $error("irq stayed after expired read");
   mask_off_a: assert property (done_s ##0 avs_write
      && avs_address[5:2] == 4'h7 && avs_writedata[1:0] == 2'h0 |=> ##1 !irq)
      else $error("irq stayed with mask cleared");
   deep_hold_a: assert property (deep_sleep_active
      && $past(deep_sleep_active, 2) && !$past(avs_write)
      && !$past(avs_write, 2) |-> !$rose(irq))
      else $error("irq rose in deep sleep");
endmodule // swt_timers_sva

bind swt_timers swt_timers_sva i_swt_timers_sva (.mclk, .arst_n, .avs_address,
   .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
   .sleep_active, .deep_sleep_active, .irq, .wake_event);

/* sim/tb_top.sv */
// self-checking bench for the wakeup timer block
module tb_top
   import swt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // stimulus and checks
   // ****************************************
   logic        mclk = 1'h0, arst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
   logic        rc_osc_clk = 1'h0, ext_clk = 1'h0, use_ext = 1'h0;
   logic        sleep_active = 1'h0, deep_sleep_active = 1'h0;
   logic        avs_waitrequest, irq, wake_event;
   logic [5:0]  avs_address = 6'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q, cal;
   int          miscompares = 0, total_checks = 0;

   initial forever #25 mclk = ~mclk;
   // offset keeps rc_osc_clk edges off the mclk edges; ext_clk edges land on them
   initial
   begin
      #10;
      forever #15625 rc_osc_clk = ~rc_osc_clk;
   end
   initial forever #7000 ext_clk = ~ext_clk;

   swt_timers i_swt_timers (.mclk, .arst_n, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .rc_osc_clk,
      .external_slow_ref_input(ext_clk), .sleep_active, .deep_sleep_active,
      .irq, .wake_event);

   task automatic chk(input string s, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", s, e, g);
      end
   endtask

   // request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (avs_waitrequest !== 1'h0 && n < 50);
      if (avs_waitrequest !== 1'h0)
      begin
         miscompares++;
         $display("unexpected waitrequest: expected 0 seen %b",
                  avs_waitrequest);
      end
      q = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask

   task automatic rdc(input string s, input logic [5:0] a,
                      input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      chk(s, e, q);
   endtask

   // margin after the edge covers the tick synchroniser lag
   task automatic tk(input int n);
      repeat (n) @(posedge (use_ext ? ext_clk : rc_osc_clk));
      repeat (12) @(posedge mclk);
   endtask

   task automatic t_regs;
      rdc("ctrl reset", 6'h00, SWT_CTRL_RST);
      rdc("mask reset", 6'h1c, 32'h0);
      rdc("count0 reset", 6'h0c, 32'h0);
      bus(1'h1, 6'h3c, 32'hffff_ffff);
      rdc("unmapped", 6'h3c, 32'h0);
      $display("register test done");
   endtask

   task automatic t_count;
      tk(1);
      bus(1'h1, 6'h1c, 32'h3);
      bus(1'h1, 6'h04, 32'h3);
      rdc("running", 6'h14, 32'h1);
      tk(3);
      chk("irq at zero", 32'h1, irq);
      sleep_active <= 1'h1;
      @(posedge mclk);
      @(posedge mclk);
      chk("wake event", 32'h1, wake_event);
      sleep_active <= 1'h0;
      rdc("expired", 6'h18, 32'h1);
      rdc("expired cleared", 6'h18, 32'h0);
      tk(2);
      rdc("past zero", 6'h0c, 32'hffff_fffe);
      bus(1'h1, 6'h24, 32'h3);
      $display("count test done");
   endtask

   task automatic t_stop;
      tk(1);
      bus(1'h1, 6'h08, 32'h2);
      tk(1);
      bus(1'h1, 6'h24, 32'h2);
      tk(3);
      rdc("stopped count", 6'h10, 32'h1);
      rdc("not running", 6'h14, 32'h0);
      chk("no irq", 32'h0, irq);
      $display("stop test done");
   endtask

   task automatic t_sleep;
      bus(1'h1, 6'h00, 32'h1);
      sleep_active <= 1'h1;
      tk(1);
      bus(1'h1, 6'h04, 32'ha);
      bus(1'h1, 6'h08, 32'ha);
      tk(3);
      rdc("runs in sleep", 6'h0c, 32'h7);
      rdc("off in sleep", 6'h10, 32'ha);
      deep_sleep_active <= 1'h1;
      tk(3);
      rdc("deep sleep", 6'h0c, 32'h7);
      deep_sleep_active <= 1'h0;
      sleep_active <= 1'h0;
      bus(1'h1, 6'h24, 32'h3);
      bus(1'h1, 6'h00, 32'h3);
      $display("sleep test done");
   endtask

   task automatic t_mask;
      bus(1'h1, 6'h1c, 32'h0);
      tk(1);
      bus(1'h1, 6'h08, 32'h1);
      tk(2);
      chk("masked irq", 32'h0, irq);
      rdc("masked expiry", 6'h18, 32'h2);
      bus(1'h1, 6'h24, 32'h3);
      $display("mask test done");
   endtask

   task automatic t_ext;
      bus(1'h1, 6'h00, 32'h7);
      use_ext = 1'h1;
      tk(1);
      bus(1'h1, 6'h04, 32'ha);
      tk(4);
      rdc("external ticks", 6'h0c, 32'h6);
      bus(1'h1, 6'h24, 32'h3);
      bus(1'h1, 6'h00, 32'h3);
      use_ext = 1'h0;
      $display("external clock test done");
   endtask

   // start lands a few mclk after a tick, so the count sits just under nominal
   task automatic t_cal;
      tk(1);
      bus(1'h1, 6'h04, SWT_CAL_TICKS);
      bus(1'h1, 6'h24, 32'h1);
      rdc("cal preload", 6'h0c, SWT_CAL_TICKS);
      bus(1'h1, 6'h00, 32'hb);
      tk(SWT_CAL_TICKS);
      bus(1'h0, 6'h14, 32'h0);
      chk("cal done", 32'h1, q[SWT_STAT_CALDONE]);
      bus(1'h0, 6'h20, 32'h0);
      cal = q;
      chk("cal span", 32'h1, cal >= SWT_CAL_NOM - 40
          && cal <= SWT_CAL_NOM + 10);
      tk(1);
      rdc("cal hold", 6'h20, cal);
      bus(1'h1, 6'h00, 32'h3);
      $display("calibration test done");
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      repeat (16) @(posedge mclk);
      arst_n <= 1'h1;
      t_regs;
      t_count;
      t_stop;
      t_sleep;
      t_mask;
      t_ext;
      t_cal;
      final_report;
   end

   initial
   begin
      repeat (60000) @(posedge mclk);
      miscompares++;
      final_report;
   end
endmodule // tb_top
